/* File: rtl/flash_prog_host.sv */
// Host-side program, read and identification controller for a parallel flash
// Operation
// R01 - Output drive high while strobe and select low
// R02 - Same sector address at every load strobe
// R03 - Load all 64 bytes of the sector
// R04 - Protection returns after each program cycle
// R05 - Next byte load within the load window
// R06 - Toggling drive or select toggles status bit
// R07 - Toggle bit start and end values vary
// R08 - Polling address stays constant throughout
// R09 - Identification mode returns maker or part code
// R10 - Power loss leaves identification mode
// R11 - Exit sequence restores normal array reads
// R12 - Wait for program completion before new commands
// R13 - Protection code written before first byte load
`timescale 1ns/1ps
`default_nettype none
`include "flash_prog_regs.svh"

module flash_prog_host #(
  parameter int BLC_CYC = (`FP_T_BLC_US * 1000) / `FP_CLK_NS,
  parameter int WC_CYC  = (`FP_T_WC_MS * 1000000) / `FP_CLK_NS
) (
  // Clock and reset
  input  wire logic                  MCLK_I,
  input  wire logic                  NRST_I,
  // Command port
  input  wire logic                  CMD_VALID_I,
  output logic                       CMD_READY_O,
  input  wire logic [1:0]            CMD_OP_I,
  input  wire logic [`FP_ADDR_W-1:0] CMD_ADDR_I,
  // Sector data stream
  input  wire logic                  DATA_VALID_I,
  output logic                       DATA_READY_O,
  input  wire logic [`FP_DATA_W-1:0] DATA_I,
  // Result
  output logic                       DONE_O,
  output logic                       BUSY_O,
  output logic                       ERR_O,
  output logic [`FP_DATA_W-1:0]      RD_DATA_O,
  // Flash pins
  output logic                       FL_CE_N_O,
  output logic                       FL_OE_N_O,
  output logic                       FL_WE_N_O,
  output logic [`FP_ADDR_W-1:0]      FL_ADDR_O,
  input  wire logic [`FP_DATA_W-1:0] FL_DQ_I,
  output logic [`FP_DATA_W-1:0]      FL_DQ_O,
  output logic                       FL_DQ_OE_O
);

  function automatic logic [7:0] cyc(input int ns);
    cyc = 8'((ns + `FP_CLK_NS - 1) / `FP_CLK_NS);
  endfunction

  localparam logic [7:0] AS_CYC   = (cyc(`FP_T_AS_NS) < 8'h1) ? 8'h1 : cyc(`FP_T_AS_NS);
  localparam logic [7:0] WP_CYC   = cyc(`FP_T_WP_NS);
  localparam logic [7:0] WPH_CYC  = cyc(`FP_T_WPH_NS);
  localparam logic [7:0] ACC_CYC  = cyc(`FP_T_ACC_NS);
  localparam logic [7:0] OEHP_CYC = cyc(`FP_T_OEHP_NS);
  localparam logic [6:0] CMD_N    = 7'(`FP_CMD_STEPS);
  localparam logic [6:0] END_STEP = 7'(`FP_CMD_STEPS + `FP_SECTOR_BYTES);

  if (BLC_CYC < 16 || BLC_CYC >= (1 << 20) || WC_CYC < 16 || WC_CYC >= (1 << 20)) begin : g_chk
    $error("Load window and program cycle counts must fit 20 bits");
  end

  // Address and data of one step of a command code sequence
  function automatic logic [`FP_ADDR_W+`FP_DATA_W-1:0] code_word(input logic [1:0] op, input logic [6:0] step);
    logic [`FP_DATA_W-1:0] last;
    last = (op == `FP_OP_PROG) ? `FP_CODE_PROG :
           (op == `FP_OP_ID_ENTER) ? `FP_CODE_ID_IN : `FP_CODE_ID_OUT; // [R11]
    case (step)
      7'h0:    code_word = {`FP_CODE_ADDR_A, `FP_CODE_DAT_A};
      7'h1:    code_word = {`FP_CODE_ADDR_B, `FP_CODE_DAT_B};
      default: code_word = {`FP_CODE_ADDR_A, last};
    endcase
  endfunction

  flash_prog_pkg::ctl_t q;
  flash_prog_pkg::ctl_t n;

  logic                  fifo_valid;
  logic                  fifo_pop;
  logic [`FP_DATA_W-1:0] fifo_data;

  flash_byte_fifo #(
    .W (`FP_DATA_W),
    .D (`FP_FIFO_DEPTH)
  ) u_flash_byte_fifo (
    .clk_i       (MCLK_I),
    .nrst_i      (NRST_I),
    .in_valid_i  (DATA_VALID_I),
    .in_ready_o  (DATA_READY_O),
    .in_data_i   (DATA_I),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data)
  );

  always_comb begin
    logic [6:0] idx;
    idx      = q.step - CMD_N;
    n        = q;
    fifo_pop = 1'h0;
    if (q.polling || q.st == flash_prog_pkg::S_RECOV || q.st == flash_prog_pkg::S_LOADWAIT ||
        q.st == flash_prog_pkg::S_SETUP) begin
      n.wtmr = q.wtmr + 20'h1;
    end
    case (q.st)
      flash_prog_pkg::S_IDLE: begin
        if (CMD_VALID_I) begin
          n.op        = CMD_OP_I;
          n.base      = CMD_ADDR_I;
          n.step      = 7'h0;
          n.err       = 1'h0;
          n.fin       = 1'h0;
          n.polling   = 1'h0;
          n.have_prev = 1'h0;
          if (CMD_OP_I == `FP_OP_READ) begin
            n.addr = CMD_ADDR_I;
            n.ce_n = 1'h0;
            n.oe_n = 1'h0;
            n.tmr  = ACC_CYC - 8'h1;
            n.st   = flash_prog_pkg::S_RD_ACC;
          end else begin
            {n.addr, n.dout} = code_word(CMD_OP_I, 7'h0); // [R04] [R13]
            n.dq_oe          = 1'h1;
            n.tmr            = AS_CYC - 8'h1;
            n.st             = flash_prog_pkg::S_SETUP;
          end
        end
      end
      flash_prog_pkg::S_SETUP: begin
        if (q.tmr == 8'h0) begin
          n.ce_n = 1'h0;
          n.we_n = 1'h0; // [R01]
          n.tmr  = WP_CYC - 8'h1;
          n.st   = flash_prog_pkg::S_PULSE;
        end else begin
          n.tmr = q.tmr - 8'h1;
        end
      end
      flash_prog_pkg::S_PULSE: begin
        if (q.tmr == 8'h0) begin
          n.ce_n = 1'h1;
          n.we_n = 1'h1;
          n.tmr  = WPH_CYC - 8'h1;
          n.wtmr = 20'h0;
          n.step = q.step + 7'h1;
          n.st   = flash_prog_pkg::S_RECOV;
        end else begin
          n.tmr = q.tmr - 8'h1;
        end
      end
      flash_prog_pkg::S_RECOV: begin
        if (q.tmr != 8'h0) begin
          n.tmr = q.tmr - 8'h1;
        end else if (q.op != `FP_OP_PROG && q.step == CMD_N) begin
          n.dq_oe = 1'h0;
          n.st    = flash_prog_pkg::S_DONE;
        end else if (q.step == END_STEP) begin
          n.dq_oe   = 1'h0;
          n.polling = 1'h1; // [R03]
          n.wtmr    = 20'h0;
          n.addr    = q.base; // [R08]
          n.ce_n    = 1'h0;
          n.oe_n    = 1'h0;
          n.tmr     = ACC_CYC - 8'h1;
          n.st      = flash_prog_pkg::S_RD_ACC;
        end else if (q.step < CMD_N) begin
          {n.addr, n.dout} = code_word(q.op, q.step); // [R13]
          n.tmr            = AS_CYC - 8'h1;
          n.st             = flash_prog_pkg::S_SETUP;
        end else begin
          n.st = flash_prog_pkg::S_LOADWAIT;
        end
      end
      flash_prog_pkg::S_LOADWAIT: begin
        if (fifo_valid) begin
          fifo_pop = 1'h1;
          n.addr   = {q.base[`FP_ADDR_W-1:`FP_SECT_LSB], idx[`FP_SECT_LSB-1:0]}; // [R02]
          n.dout   = fifo_data;
          n.tmr    = AS_CYC - 8'h1;
          n.st     = flash_prog_pkg::S_SETUP;
        end else if (q.wtmr >= 20'(BLC_CYC) - 20'(AS_CYC)) begin
          n.err     = 1'h1; // [R05]
          n.dq_oe   = 1'h0;
          n.polling = 1'h1;
          n.wtmr    = 20'h0;
          n.addr    = q.base;
          n.ce_n    = 1'h0;
          n.oe_n    = 1'h0;
          n.tmr     = ACC_CYC - 8'h1;
          n.st      = flash_prog_pkg::S_RD_ACC;
        end
      end
      flash_prog_pkg::S_RD_ACC: begin
        if (q.tmr == 8'h0) begin
          n.rdata = FL_DQ_I;
          n.ce_n  = 1'h1;
          n.oe_n  = 1'h1; // [R06]
          n.tmr   = OEHP_CYC - 8'h1;
          n.st    = flash_prog_pkg::S_RD_GAP;
          if (q.polling) begin
            n.prev6     = FL_DQ_I[`FP_TOGGLE_BIT];
            n.have_prev = 1'h1;
            n.fin       = q.have_prev && (q.prev6 == FL_DQ_I[`FP_TOGGLE_BIT]); // [R07]
          end
        end else begin
          n.tmr = q.tmr - 8'h1;
        end
      end
      flash_prog_pkg::S_RD_GAP: begin
        if (q.tmr != 8'h0) begin
          n.tmr = q.tmr - 8'h1;
        end else if (!q.polling || q.fin) begin
          n.st = flash_prog_pkg::S_DONE;
        end else if (q.wtmr >= 20'(WC_CYC)) begin
          n.err = 1'h1;
          n.st  = flash_prog_pkg::S_DONE;
        end else begin
          n.ce_n = 1'h0;
          n.oe_n = 1'h0; // [R06]
          n.tmr  = ACC_CYC - 8'h1;
          n.st   = flash_prog_pkg::S_RD_ACC;
        end
      end
      flash_prog_pkg::S_DONE: begin
        n.polling = 1'h0;
        n.st      = flash_prog_pkg::S_IDLE;
      end
      default: begin
        n.st = flash_prog_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      q      <= '0;
      q.st   <= flash_prog_pkg::S_IDLE;
      q.ce_n <= 1'h1;
      q.oe_n <= 1'h1;
      q.we_n <= 1'h1;
    end else begin
      q <= n;
    end
  end

  assign CMD_READY_O = (q.st == flash_prog_pkg::S_IDLE); // [R12]
  assign BUSY_O      = (q.st != flash_prog_pkg::S_IDLE);
  assign DONE_O      = (q.st == flash_prog_pkg::S_DONE);
  assign ERR_O       = q.err;
  assign RD_DATA_O   = q.rdata;
  assign FL_CE_N_O   = q.ce_n;
  assign FL_OE_N_O   = q.oe_n;
  assign FL_WE_N_O   = q.we_n;
  assign FL_ADDR_O   = q.addr;
  assign FL_DQ_O     = q.dout;
  assign FL_DQ_OE_O  = q.dq_oe;

  oe_during_write_a: assert property ( // [R01]
    @(posedge MCLK_I) disable iff (!NRST_I) (!q.we_n && !q.ce_n) |-> (q.oe_n && q.dq_oe))
    else $error("Output drive low during a write strobe");
  sector_addr_hold_a: assert property ( // [R02]
    @(posedge MCLK_I) disable iff (!NRST_I)
    ($fell(q.we_n) && q.op == `FP_OP_PROG && q.step >= CMD_N) |->
    (q.addr[`FP_ADDR_W-1:`FP_SECT_LSB] == q.base[`FP_ADDR_W-1:`FP_SECT_LSB]))
    else $error("Sector address changed during byte loads");
  all_bytes_a: assert property ( // [R03]
    @(posedge MCLK_I) disable iff (!NRST_I) $rose(q.polling) |-> (q.step == END_STEP || q.err))
    else $error("Polling started before the whole sector was loaded");
  code_first_a: assert property ( // [R04] [R13]
    @(posedge MCLK_I) disable iff (!NRST_I)
    (q.st == flash_prog_pkg::S_IDLE && CMD_VALID_I && CMD_OP_I == `FP_OP_PROG) |=>
    (q.addr == `FP_CODE_ADDR_A && q.dout == `FP_CODE_DAT_A && q.dq_oe))
    else $error("Program did not begin with the protection code");
  load_window_a: assert property ( // [R05]
    @(posedge MCLK_I) disable iff (!NRST_I) (q.st == flash_prog_pkg::S_LOADWAIT) |-> (q.wtmr < 20'(BLC_CYC)))
    else $error("Byte load window exceeded");
  write_pulse_a: assert property ( // Write pulse holds strobe and select low for at least 8 cycles
    @(posedge MCLK_I) disable iff (!NRST_I) $fell(q.we_n) |-> (!q.we_n && !q.ce_n) [*8])
    else $error("Write pulse shorter than its minimum");
  poll_toggle_a: assert property ( // [R06]
    @(posedge MCLK_I) disable iff (!NRST_I)
    (q.polling && q.st == flash_prog_pkg::S_RD_ACC && q.tmr == 8'h0) |=> (q.oe_n && q.ce_n) [*6])
    else $error("Drive not released between status reads");
  poll_end_a: assert property ( // [R07]
    @(posedge MCLK_I) disable iff (!NRST_I) $rose(q.fin) |-> ($past(q.have_prev) && q.polling))
    else $error("Completion taken from a single status read");
  poll_addr_a: assert property ( // [R08]
    @(posedge MCLK_I) disable iff (!NRST_I) (q.polling && $past(q.polling)) |-> $stable(q.addr))
    else $error("Polling address moved");
  busy_refuse_a: assert property ( // [R12]
    @(posedge MCLK_I) disable iff (!NRST_I) (q.polling && !q.fin) |-> (!CMD_READY_O && q.we_n))
    else $error("Command accepted while a program cycle runs");

endmodule

`default_nettype wire

/* File: rtl/flash_prog_regs.svh */
// Constants for the parallel flash program controller
`ifndef FLASH_PROG_REGS_SVH
`define FLASH_PROG_REGS_SVH

// Clock period and pin timing
`define FP_CLK_NS       25
`define FP_T_AS_NS      10
`define FP_T_WP_NS      200
`define FP_T_WPH_NS     200
`define FP_T_ACC_NS     250
`define FP_T_OEHP_NS    150
`define FP_T_BLC_US     150
`define FP_T_WC_MS      20

// Array geometry
`define FP_ADDR_W       15
`define FP_DATA_W       8
`define FP_SECT_LSB     6
`define FP_SECTOR_BYTES 64
`define FP_CMD_STEPS    3
`define FP_TOGGLE_BIT   6
`define FP_FIFO_DEPTH   16

// Host command codes
`define FP_OP_READ      2'h0
`define FP_OP_PROG      2'h1
`define FP_OP_ID_ENTER  2'h2
`define FP_OP_ID_EXIT   2'h3

// Default protection and identification code words
`define FP_CODE_ADDR_A  15'h5555
`define FP_CODE_ADDR_B  15'h2aaa
`define FP_CODE_DAT_A   8'haa
`define FP_CODE_DAT_B   8'h55
`define FP_CODE_PROG    8'ha0
`define FP_CODE_ID_IN   8'h90
`define FP_CODE_ID_OUT  8'hf0

`endif

/* File: rtl/flash_prog_pkg.sv */
// Types for the parallel flash program controller
`default_nettype none
`include "flash_prog_regs.svh"

package flash_prog_pkg;

  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_PULSE, S_RECOV, S_LOADWAIT, S_RD_ACC, S_RD_GAP, S_DONE
  } state_t;

  typedef struct packed {
    state_t                  st;
    logic [1:0]              op;
    logic [6:0]              step;
    logic [7:0]              tmr;
    logic [19:0]             wtmr;
    logic [`FP_ADDR_W-1:0]   base;
    logic [`FP_ADDR_W-1:0]   addr;
    logic [`FP_DATA_W-1:0]   dout;
    logic [`FP_DATA_W-1:0]   rdata;
    logic                    ce_n;
    logic                    oe_n;
    logic                    we_n;
    logic                    dq_oe;
    logic                    prev6;
    logic                    have_prev;
    logic                    polling;
    logic                    fin;
    logic                    err;
  } ctl_t;

endpackage

`default_nettype wire

/* File: rtl/flash_byte_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module flash_byte_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  localparam int AW = $clog2(D);

  if (D < 2 || (1 << AW) != D) begin : g_chk
    $error("FIFO depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0]         wp;
    logic [AW:0]         rp;
  } fifo_t;

  fifo_t q;
  fifo_t n;

  logic full;
  logic empty;

  assign full        = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
  assign empty       = (q.wp == q.rp);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = q.mem[q.rp[AW-1:0]];

  always_comb begin
    n = q;
    if (in_valid_i && !full) begin
      n.mem[q.wp[AW-1:0]] = in_data_i;
      n.wp                = q.wp + (AW+1)'(1);
    end
    if (out_ready_i && !empty) begin
      n.rp = q.rp + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

endmodule

`default_nettype wire

/* File: verif/flash_dev_model.sv */
// Behavioural model of the parallel flash device driven by the program controller
`timescale 1ns/1ps
`default_nettype none
`include "flash_prog_regs.svh"

module flash_dev_model #(
  parameter int         PROG_NS    = 20000,
  parameter int         LOAD_NS    = 4000,
  parameter logic [7:0] MAKER_CODE = 8'h3c,  // Arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h7e   // Arbitrary value
) (
  // Flash pins
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [14:0] addr_i,
  input  wire logic [7:0]  dq_i,
  output logic [7:0]       dq_o
);
  logic [7:0]  mem [32768];
  logic [7:0]  page [64];
  logic [63:0] loaded;
  logic [8:0]  sect;
  logic [7:0]  held;
  logic [1:0]  step;
  logic        open, id_mode, busy, tog, b7;
  int          cnt;
  realtime     t_last;
  wire         wr = !ce_n_i && !we_n_i;
  wire         rd = !ce_n_i && !oe_n_i;
  wire  [7:0]  rval = busy ? {~b7, tog, 6'h00} :
                     (id_mode && addr_i[14:1] == 14'h0) ? (addr_i[0] ? PART_CODE : MAKER_CODE) :
                     mem[addr_i];

  // Released bus shows the inverse of the last driven value
  assign dq_o = rd ? rval : ~held;

  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    step = 2'h0;
    open = 1'b0;
    busy = 1'b0;
    tog = 1'b0;
    b7 = 1'b0;
    id_mode = 1'b0;
    loaded = '0;
    cnt = 0;
    held = 8'h00;
    sect = 9'h0;
    t_last = 0;
  end

  always @(negedge rd) held = rval;
  always @(posedge rd) if (busy) tog = ~tog;

  // Code words and byte loads; ignored while a program cycle runs
  always @(negedge wr) begin
    if (!busy && open) begin
      page[addr_i[5:0]] = dq_i;
      loaded[addr_i[5:0]] = 1'b1;
      sect = addr_i[14:6];
      b7 = dq_i[7];
      cnt++;
      t_last = $realtime;
    end else if (!busy) begin
      case (step)
        2'h0: step = (addr_i == `FP_CODE_ADDR_A && dq_i == `FP_CODE_DAT_A) ? 2'h1 : 2'h0;
        2'h1: step = (addr_i == `FP_CODE_ADDR_B && dq_i == `FP_CODE_DAT_B) ? 2'h2 : 2'h0;
        default: begin
          step = 2'h0;
          open = (addr_i == `FP_CODE_ADDR_A && dq_i == `FP_CODE_PROG);
          t_last = $realtime;
          if (dq_i == `FP_CODE_ID_IN) id_mode = 1'b1;
          if (dq_i == `FP_CODE_ID_OUT) id_mode = 1'b0;
        end
      endcase
    end
  end

  // Program cycle starts on a full sector or when the load window lapses
  always #100 begin
    if (open && (cnt == 64 || $realtime - t_last > LOAD_NS)) begin
      busy = 1'b1;
      open = 1'b0;
      #PROG_NS;
      for (int k = 0; k < 64; k++) mem[{sect, 6'(k)}] = loaded[k] ? page[k] : 8'h00;
      busy = 1'b0;
      loaded = '0;
      cnt = 0;
    end
  end
endmodule
`default_nettype wire

/* File: verif/flash_prog_host_test.sv */
// Testbench for the parallel flash program controller
`timescale 1ns/1ps
`default_nettype none
`include "flash_prog_regs.svh"

module flash_prog_host_test;
  localparam int         CEIL  = 20000;
  localparam logic [7:0] MAKER = 8'h3c;  // Arbitrary value
  localparam logic [7:0] PART  = 8'h7e;  // Arbitrary value
  logic        mclk, nrst, cmd_valid, data_valid;
  logic [1:0]  cmd_op;
  logic [14:0] cmd_addr, fl_addr;
  logic [7:0]  data, rd_data, fl_dq_out, dev_dq;
  logic        cmd_ready, data_ready, done, busy, err, ce_n, oe_n, we_n, fl_dq_oe;
  int          miscompares, num_checks;
  int          cycles = 0;
  wire  [7:0]  dq_bus = fl_dq_oe ? fl_dq_out : dev_dq;

  flash_prog_host #(.BLC_CYC(200), .WC_CYC(2000)) u_flash_prog_host (
    .MCLK_I(mclk), .NRST_I(nrst), .CMD_VALID_I(cmd_valid), .CMD_READY_O(cmd_ready), .CMD_OP_I(cmd_op),
    .CMD_ADDR_I(cmd_addr), .DATA_VALID_I(data_valid), .DATA_READY_O(data_ready), .DATA_I(data),
    .DONE_O(done), .BUSY_O(busy), .ERR_O(err), .RD_DATA_O(rd_data), .FL_CE_N_O(ce_n), .FL_OE_N_O(oe_n),
    .FL_WE_N_O(we_n), .FL_ADDR_O(fl_addr), .FL_DQ_I(dq_bus), .FL_DQ_O(fl_dq_out), .FL_DQ_OE_O(fl_dq_oe));

  flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_flash_dev_model (
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(fl_addr), .dq_i(dq_bus), .dq_o(dev_dq));

  always #12.5 mclk = ~mclk;

  function automatic logic [7:0] pat(input int i);
    return 8'(i * 7 + 3);
  endfunction

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s: got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One command, held until taken, then wait for its completion pulse
  task automatic cmd(input logic [1:0] op, input logic [14:0] a);
    int n;
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    do @(posedge mclk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    @(posedge mclk);
    chk_flag(busy, 1'b1, "busy after accept");
    n = 0;
    while (done !== 1'b1 && n < 5000) begin
      @(posedge mclk);
      n++;
    end
    if (n == 5000) chk_flag(1'b0, 1'b1, "command never completed");
  endtask

  task automatic push_n(input int first, input int n);
    for (int i = first; i < first + n; i++) begin
      data_valid <= 1'b1;
      data <= pat(i);
      do @(posedge mclk); while (data_ready !== 1'b1);
    end
    data_valid <= 1'b0;
  endtask

  task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
    cmd(`FP_OP_READ, a);
    chk_byte(rd_data, exp, "read data");
  endtask

  // Fill the buffer with 16 bytes and check that it refuses, then program while streaming the rest
  task automatic t_program();
    push_n(0, 16);
    @(posedge mclk);
    chk_flag(data_ready, 1'b0, "buffer full");
    fork
      cmd(`FP_OP_PROG, 15'h00c0);
      push_n(16, 50);
    join
    chk_flag(err, 1'b0, "program error");
    rd_chk(15'h00c0, pat(0));
    rd_chk(15'h00ff, pat(63));
    rd_chk(15'h0100, 8'hff);
  endtask

  // Leftover bytes start the next sector; protection must be re-entered
  task automatic t_second();
    fork
      cmd(`FP_OP_PROG, 15'h0140);
      push_n(66, 62);
    join
    chk_flag(err, 1'b0, "second program error");
    rd_chk(15'h0140, pat(64));
    rd_chk(15'h017f, pat(127));
  endtask

  // Stream stops short; the load window lapses
  task automatic t_partial();
    push_n(128, 10);
    @(posedge mclk);
    cmd(`FP_OP_PROG, 15'h01c0);
    chk_flag(err, 1'b1, "load window error");
    rd_chk(15'h01c9, pat(137));
    chk_flag(err, 1'b0, "error cleared");
  endtask

  task automatic t_ident();
    cmd(`FP_OP_ID_ENTER, 15'h0000);
    rd_chk(15'h0000, MAKER);
    rd_chk(15'h0001, PART);
    cmd(`FP_OP_ID_EXIT, 15'h0000);
    rd_chk(15'h0000, 8'hff);
    rd_chk(15'h00c1, pat(1));
  endtask

  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_addr = 15'h0000;
    data_valid = 1'b0;
    data = 8'h00;
    miscompares = 0;
    num_checks = 0;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_program();
    t_second();
    t_partial();
    t_ident();
    finish_test();
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == CEIL) begin
      miscompares++;
      finish_test();
    end
  end
endmodule
`default_nettype wire
